// [hdl/dssc_defines.svh]
// Offsets, field positions, reset values and prescaler moduli of the serial configuration port
// Overview of operation
// - Data shifts into 22-bit register, MSB first
// - Load strobe rise copies word to one latch
// - Select 00 second reference, 01 first reference
// - Select 10 second feedback, 11 first feedback
// - Reference ratio bits 1-15, 3..32767 only
// - Swallow count bits 1-7, any 0..127
// - Main count bits 8-18, 3..2047 only
// - Feedback divides by modulus times main plus swallow
// - Bit 19 picks modulus, bit 20 powerdown
// - Reference bit 16 sets detector polarity
// - Reference bit 17 selects full or quarter current
// - Reference bit 18 puts pump in high impedance
// - Lock-detect bits pick output when functions zero
// - Disabled output is driven low
// - One function bit shows divider output
// - Both function bits: fast acquisition or counter reset
// - Fast acquisition grounds resistor when current high
// - Lock output high while selected loops locked
// - Pump active at powerdown gives synchronous powerdown
// - Pump high-z at powerdown gives asynchronous powerdown
// - Synchronous waits for pump idle; asynchronous immediate
// - Powered-down loop holds dividers; oscillator until both
// - Serial port keeps working during powerdown
// - Latching zero powerdown bit powers up at once
`ifndef DSSC_DEFINES_SVH
`define DSSC_DEFINES_SVH

`define DSSC_SHIFT_WIDTH     22
`define DSSC_LATCH_WIDTH     20
`define DSSC_OFS_REF2        2'h0
`define DSSC_OFS_REF1        2'h1
`define DSSC_OFS_FB2         2'h2
`define DSSC_OFS_FB1         2'h3
`define DSSC_REF_RATIO_LSB   0
`define DSSC_REF_RATIO_MSB   14
`define DSSC_POLARITY_POS    15
`define DSSC_CURRENT_POS     16
`define DSSC_HIGHZ_POS       17
`define DSSC_LOCKSEL_POS     18
`define DSSC_OUTFUNC_POS     19
`define DSSC_SWALLOW_LSB     0
`define DSSC_SWALLOW_MSB     6
`define DSSC_MAIN_LSB        7
`define DSSC_MAIN_MSB        17
`define DSSC_MODULUS_POS     18
`define DSSC_POWERDOWN_POS   19
`define DSSC_LATCH_RESET     20'h00000
`define DSSC_MOD_LOW         8'h40
`define DSSC_MOD_HIGH        8'h80

`endif

// [hdl/dssc_pkg.sv]
// Types shared by the serial configuration block
package dssc_pkg;

    typedef struct packed {
        logic [14:0] ratio;
        logic        polarity;
        logic        currentLevel;
        logic        pumpHighz;
        logic        lockSel;
        logic        outFunc;
    } dssc_ref_s;

    typedef struct packed {
        logic [10:0] mainCount;
        logic [6:0]  swallowCount;
        logic        modulusSel;
        logic        powerdown;
    } dssc_fb_s;

    typedef struct packed {
        logic        polarity;
        logic        fullCurrent;
        logic        pumpHighz;
        logic        counterReset;
        logic        poweredDown;
        logic [7:0]  modulus;
        logic [18:0] fbRatio;
    } dssc_loop_s;

    typedef enum logic [2:0] {
        DSSC_PD_ACTIVE  = 3'b001,
        DSSC_PD_WAIT    = 3'b010,
        DSSC_PD_DOWN    = 3'b100
    } dssc_pd_e;

endpackage : dssc_pkg

// [hdl/dssc_sync.sv]
// Two-flop synchroniser with rising-edge detector for the serial pins
`timescale 1ns/1ps
module dssc_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Pin in
    input  wire logic pinIn,
    // Synchronised level and edge
    output logic      level,
    output logic      rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
endmodule : dssc_sync

// [hdl/dssc_powerdown.sv]
// Per-loop powerdown sequencer: synchronous or asynchronous entry
`timescale 1ns/1ps
module dssc_powerdown
    import dssc_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Latch event and latched bits
    input  wire logic fbLoad,
    input  wire logic powerdownBit,
    input  wire logic highzBit,
    // Charge pump idle indication
    input  wire logic pumpIdle,
    // Status
    output logic      poweredDown
);
    dssc_pd_e state_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= DSSC_PD_ACTIVE;
        end else if (fbLoad && !powerdownBit) begin
            state_reg <= DSSC_PD_ACTIVE;
        end else if (fbLoad && powerdownBit && state_reg == DSSC_PD_ACTIVE) begin
            if (highzBit) begin
                state_reg <= DSSC_PD_DOWN;
            end else begin
                state_reg <= DSSC_PD_WAIT;
            end
        end else begin
            unique case (state_reg)
                DSSC_PD_WAIT: begin
                    if (pumpIdle) begin
                        state_reg <= DSSC_PD_DOWN;
                    end
                end
                DSSC_PD_ACTIVE, DSSC_PD_DOWN: begin
                    state_reg <= state_reg;
                end
                default: begin
                    state_reg <= DSSC_PD_ACTIVE;
                end
            endcase
        end
    end

    assign poweredDown = (state_reg == DSSC_PD_DOWN);
endmodule : dssc_powerdown

// [hdl/dssc_serial_config.sv]
// Serial programming port, configuration latches and output multiplexer
`timescale 1ns/1ps
`include "dssc_defines.svh"
module dssc_serial_config
    import dssc_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_b,
    // Serial programming pins
    input  wire logic               serialData,
    input  wire logic               serialClock,
    input  wire logic               load_strobe,
    // Loop status from analog side
    input  wire logic               loop1Locked,
    input  wire logic               loop2Locked,
    input  wire logic               loop1PumpIdle,
    input  wire logic               loop2PumpIdle,
    input  wire logic               loop1RefOut,
    input  wire logic               loop2RefOut,
    input  wire logic               loop1FbOut,
    input  wire logic               loop2FbOut,
    // Loop settings
    output dssc_pkg::dssc_ref_s     first_loopRef,
    output dssc_pkg::dssc_ref_s     second_loopRef,
    output dssc_pkg::dssc_fb_s      first_loopFb,
    output dssc_pkg::dssc_fb_s      second_loopFb,
    output dssc_pkg::dssc_loop_s    first_loopCtrl,
    output dssc_pkg::dssc_loop_s    second_loopCtrl,
    output logic                    oscEnable,
    // Multi-function pin, open drain when switching resistor
    output logic                    multi_function_output,
    output logic                    multiFunctionOe
);
    import dssc_pkg::*;

    logic                          dataLevel;
    logic                          clkRise;
    logic                          strobeRise;
    logic [`DSSC_SHIFT_WIDTH-1:0]  shift_reg;
    dssc_ref_s                     ref1_reg;
    dssc_ref_s                     ref2_reg;
    dssc_fb_s                      fb1_reg;
    dssc_fb_s                      fb2_reg;
    logic                          pd1;
    logic                          pd2;
    logic                          fb1Load;
    logic                          fb2Load;
    logic [1:0]                    lockSel;
    logic [1:0]                    outFunc;
    logic                          fastMode;
    logic                          reset1;
    logic                          reset2;
    logic                          mfoNext;
    logic                          mfoOeNext;
    logic                          mfo_reg;
    logic                          mfoOe_reg;

    // Latch destination decode
    function automatic logic selHit(input logic [1:0] sel, input logic [1:0] ofs);
        selHit = (sel == ofs);
    endfunction : selHit

    // Field unpacking from the upper 20 bits of the word, above the select bits
    function automatic dssc_ref_s toRef(input logic [`DSSC_LATCH_WIDTH-1:0] w);
        toRef.ratio        = w[`DSSC_REF_RATIO_MSB:`DSSC_REF_RATIO_LSB];
        toRef.polarity     = w[`DSSC_POLARITY_POS];
        toRef.currentLevel = w[`DSSC_CURRENT_POS];
        toRef.pumpHighz    = w[`DSSC_HIGHZ_POS];
        toRef.lockSel      = w[`DSSC_LOCKSEL_POS];
        toRef.outFunc      = w[`DSSC_OUTFUNC_POS];
    endfunction : toRef

    function automatic dssc_fb_s toFb(input logic [`DSSC_LATCH_WIDTH-1:0] w);
        toFb.swallowCount = w[`DSSC_SWALLOW_MSB:`DSSC_SWALLOW_LSB];
        toFb.mainCount    = w[`DSSC_MAIN_MSB:`DSSC_MAIN_LSB];
        toFb.modulusSel   = w[`DSSC_MODULUS_POS];
        toFb.powerdown    = w[`DSSC_POWERDOWN_POS];
    endfunction : toFb

    // Feedback ratio: modulus times main count plus swallow count
    function automatic logic [18:0] fbRatio(input dssc_fb_s f);
        logic [7:0] m;
        m = f.modulusSel ? `DSSC_MOD_HIGH : `DSSC_MOD_LOW;
        fbRatio = 19'(m * f.mainCount) + 19'(f.swallowCount);
    endfunction : fbRatio

    dssc_sync uSyncData (
        .clock (clock),
        .rst_b (rst_b),
        .pinIn (serialData),
        .level (dataLevel),
        .rise  ()
    );

    dssc_sync uSyncClk (
        .clock (clock),
        .rst_b (rst_b),
        .pinIn (serialClock),
        .level (),
        .rise  (clkRise)
    );

    dssc_sync uSyncStrobe (
        .clock (clock),
        .rst_b (rst_b),
        .pinIn (load_strobe),
        .level (),
        .rise  (strobeRise)
    );

    // Serial shift, never gated by powerdown
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= '0;
        end else if (clkRise) begin
            shift_reg <= {shift_reg[`DSSC_SHIFT_WIDTH-2:0], dataLevel};
        end
    end

    // Reference latches
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ref1_reg <= dssc_ref_s'(`DSSC_LATCH_RESET);
            ref2_reg <= dssc_ref_s'(`DSSC_LATCH_RESET);
        end else if (strobeRise) begin
            if (selHit(shift_reg[1:0], `DSSC_OFS_REF2)) begin
                ref2_reg <= toRef(shift_reg[`DSSC_SHIFT_WIDTH-1:2]);
            end
            if (selHit(shift_reg[1:0], `DSSC_OFS_REF1)) begin
                ref1_reg <= toRef(shift_reg[`DSSC_SHIFT_WIDTH-1:2]);
            end
        end
    end

    assign fb1Load = strobeRise && selHit(shift_reg[1:0], `DSSC_OFS_FB1);
    assign fb2Load = strobeRise && selHit(shift_reg[1:0], `DSSC_OFS_FB2);

    // Feedback latches
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fb1_reg <= dssc_fb_s'(`DSSC_LATCH_RESET);
            fb2_reg <= dssc_fb_s'(`DSSC_LATCH_RESET);
        end else begin
            if (fb2Load) begin
                fb2_reg <= toFb(shift_reg[`DSSC_SHIFT_WIDTH-1:2]);
            end
            if (fb1Load) begin
                fb1_reg <= toFb(shift_reg[`DSSC_SHIFT_WIDTH-1:2]);
            end
        end
    end

    dssc_powerdown uPd1 (
        .clock        (clock),
        .rst_b        (rst_b),
        .fbLoad       (fb1Load),
        .powerdownBit (shift_reg[`DSSC_POWERDOWN_POS+2]),
        .highzBit     (ref1_reg.pumpHighz),
        .pumpIdle     (loop1PumpIdle),
        .poweredDown  (pd1)
    );

    dssc_powerdown uPd2 (
        .clock        (clock),
        .rst_b        (rst_b),
        .fbLoad       (fb2Load),
        .powerdownBit (shift_reg[`DSSC_POWERDOWN_POS+2]),
        .highzBit     (ref2_reg.pumpHighz),
        .pumpIdle     (loop2PumpIdle),
        .poweredDown  (pd2)
    );

    assign lockSel  = {ref1_reg.lockSel, ref2_reg.lockSel};
    assign outFunc  = {ref1_reg.outFunc, ref2_reg.outFunc};
    assign fastMode = (outFunc == 2'b11) && (lockSel == 2'b00);
    assign reset2   = (outFunc == 2'b11) && ref2_reg.lockSel;
    assign reset1   = (outFunc == 2'b11) && ref1_reg.lockSel;

    // Multi-function output selection
    always_comb begin
        mfoNext   = 1'b0;
        mfoOeNext = 1'b1;
        unique case (outFunc)
            2'b00: begin
                unique case (lockSel)
                    2'b00: mfoNext = 1'b0;
                    2'b01: mfoNext = loop2Locked;
                    2'b10: mfoNext = loop1Locked;
                    2'b11: mfoNext = loop1Locked & loop2Locked;
                endcase
            end
            2'b01: begin
                mfoNext = ref2_reg.lockSel ? loop2FbOut : loop2RefOut;
            end
            2'b10: begin
                mfoNext = ref2_reg.lockSel ? loop1FbOut : loop1RefOut;
            end
            2'b11: begin
                // Resistor switch pulls low while either pump runs at full current
                if (fastMode && (ref1_reg.currentLevel || ref2_reg.currentLevel)) begin
                    mfoNext = 1'b0;
                end else begin
                    mfoOeNext = !fastMode;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mfo_reg   <= 1'b0;
            mfoOe_reg <= 1'b1;
        end else begin
            mfo_reg   <= mfoNext;
            mfoOe_reg <= mfoOeNext;
        end
    end

    assign multi_function_output = mfo_reg;
    assign multiFunctionOe       = mfoOe_reg;

    assign first_loopRef  = ref1_reg;
    assign second_loopRef = ref2_reg;
    assign first_loopFb   = fb1_reg;
    assign second_loopFb  = fb2_reg;

    // Per-loop control summary
    always_comb begin
        first_loopCtrl.polarity     = ref1_reg.polarity;
        first_loopCtrl.fullCurrent  = ref1_reg.currentLevel;
        first_loopCtrl.pumpHighz    = ref1_reg.pumpHighz | reset1 | pd1;
        first_loopCtrl.counterReset = reset1 | pd1;
        first_loopCtrl.poweredDown  = pd1;
        first_loopCtrl.modulus      = fb1_reg.modulusSel ? `DSSC_MOD_HIGH : `DSSC_MOD_LOW;
        first_loopCtrl.fbRatio      = fbRatio(fb1_reg);
        second_loopCtrl.polarity     = ref2_reg.polarity;
        second_loopCtrl.fullCurrent  = ref2_reg.currentLevel;
        second_loopCtrl.pumpHighz    = ref2_reg.pumpHighz | reset2 | pd2;
        second_loopCtrl.counterReset = reset2 | pd2;
        second_loopCtrl.poweredDown  = pd2;
        second_loopCtrl.modulus      = fb2_reg.modulusSel ? `DSSC_MOD_HIGH : `DSSC_MOD_LOW;
        second_loopCtrl.fbRatio      = fbRatio(fb2_reg);
    end

    assign oscEnable = !(pd1 && pd2);
endmodule : dssc_serial_config

// [testbench/dssc_serial_config_props.sv]
// Concurrent checks on the serial configuration block ports
`timescale 1ns/1ps
module dssc_serial_config_props
    import dssc_pkg::*;
(
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 rst_b,
    // Loop status
    input wire logic                 loop1Locked,
    input wire logic                 loop1PumpIdle,
    // Settings and outputs
    input wire dssc_pkg::dssc_ref_s  first_loopRef,
    input wire dssc_pkg::dssc_ref_s  second_loopRef,
    input wire dssc_pkg::dssc_fb_s   first_loopFb,
    input wire dssc_pkg::dssc_loop_s first_loopCtrl,
    input wire dssc_pkg::dssc_loop_s second_loopCtrl,
    input wire logic                 oscEnable,
    input wire logic                 multi_function_output,
    input wire logic                 multiFunctionOe
);
    import dssc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [3:0] modeBits;
    assign modeBits = {first_loopRef.lockSel, second_loopRef.lockSel,
                       first_loopRef.outFunc, second_loopRef.outFunc};

    a_osc_both_down: assert property (
        oscEnable == !(first_loopCtrl.poweredDown && second_loopCtrl.poweredDown))
        else $error("oscillator enable wrong");
    a_fb_ratio: assert property (
        first_loopCtrl.fbRatio == 19'(first_loopCtrl.modulus) * 19'(first_loopFb.mainCount)
            + 19'(first_loopFb.swallowCount))
        else $error("feedback ratio wrong");
    a_modulus_pick: assert property (
        first_loopCtrl.modulus == (first_loopFb.modulusSel ? 8'h80 : 8'h40))
        else $error("prescaler modulus wrong");
    a_disabled_low: assert property (
        modeBits == 4'h0 |=> !multi_function_output && multiFunctionOe)
        else $error("disabled output not driven low");
    a_lock_first: assert property (
        modeBits == 4'h8 |=> multi_function_output == $past(loop1Locked))
        else $error("lock output does not follow loop");
    a_counter_reset: assert property (
        first_loopRef.outFunc && second_loopRef.outFunc && first_loopRef.lockSel
            |-> first_loopCtrl.counterReset && first_loopCtrl.pumpHighz)
        else $error("counter reset not applied");
    a_fast_switch: assert property (
        modeBits == 4'h3 && (first_loopRef.currentLevel || second_loopRef.currentLevel)
            |=> multiFunctionOe && !multi_function_output)
        else $error("resistor switch not closed");
    a_async_down: assert property (
        $rose(first_loopFb.powerdown) && first_loopRef.pumpHighz |-> first_loopCtrl.poweredDown)
        else $error("asynchronous powerdown late");
    a_sync_done: assert property (
        first_loopFb.powerdown && !first_loopCtrl.poweredDown && loop1PumpIdle
            |-> ##[1:3] first_loopCtrl.poweredDown)
        else $error("synchronous powerdown missing");
    a_power_up: assert property (
        $fell(first_loopFb.powerdown) |-> !first_loopCtrl.poweredDown)
        else $error("loop not powered up");

    c_fast: cover property (modeBits == 4'h3 && first_loopRef.currentLevel);
    c_both_down: cover property (first_loopCtrl.poweredDown && second_loopCtrl.poweredDown);
    c_sync: cover property ($rose(first_loopCtrl.poweredDown) && !first_loopRef.pumpHighz);
endmodule : dssc_serial_config_props

bind dssc_serial_config dssc_serial_config_props dssc_serial_config_props_i (
    .clock, .rst_b, .loop1Locked, .loop1PumpIdle, .first_loopRef, .second_loopRef,
    .first_loopFb, .first_loopCtrl, .second_loopCtrl, .oscEnable,
    .multi_function_output, .multiFunctionOe);

// [testbench/dssc_host_model.sv]
// Host controller model driving the three serial programming pins
`timescale 1ns/1ps
module dssc_host_model (
    // Clock
    input  wire logic clock,
    // Serial programming pins
    output logic      serialData,
    output logic      serialClock,
    output logic      load_strobe
);
    // Half of the 320 ns serial clock, in system clocks
    localparam int HALF = 4;
    initial begin
        {serialData, serialClock, load_strobe} = 3'h0;
    end
    task automatic send(input logic [21:0] word);
        @(posedge clock);
        for (int i = 21; i >= 0; i--) begin
            serialData  <= word[i];
            repeat (HALF) @(posedge clock);
            serialClock <= 1'b1;
            repeat (HALF) @(posedge clock);
            serialClock <= 1'b0;
        end
        repeat (HALF) @(posedge clock);
        // Data not held once the frame is over
        serialData  <= ~word[0];
        load_strobe <= 1'b1;
        repeat (HALF) @(posedge clock);
        load_strobe <= 1'b0;
        repeat (2 * HALF) @(posedge clock);
        @(negedge clock);
    endtask : send
endmodule : dssc_host_model

// [testbench/dssc_serial_config_test.sv]
// Self-checking bench for the serial configuration block
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
        end \
    end
module dssc_serial_config_test;
    import dssc_pkg::*;
    logic       clock = 1'b0;
    logic       rst_b, serialData, serialClock, load_strobe;
    logic       loop1Locked, loop2Locked, loop1PumpIdle, loop2PumpIdle;
    logic       loop1RefOut, loop2RefOut, loop1FbOut, loop2FbOut;
    dssc_ref_s  first_loopRef, second_loopRef;
    dssc_fb_s   first_loopFb, second_loopFb;
    dssc_loop_s first_loopCtrl, second_loopCtrl;
    logic       oscEnable, multi_function_output, multiFunctionOe;
    int         errors = 0;
    int         total_checks = 0;
    int         seed = 99119;

    always #20 clock = ~clock;

    dssc_host_model dssc_host_model_i (.clock, .serialData, .serialClock, .load_strobe);
    dssc_serial_config dssc_serial_config_i (.clock, .rst_b, .serialData, .serialClock,
        .load_strobe, .loop1Locked, .loop2Locked, .loop1PumpIdle, .loop2PumpIdle,
        .loop1RefOut, .loop2RefOut, .loop1FbOut, .loop2FbOut, .first_loopRef,
        .second_loopRef, .first_loopFb, .second_loopFb, .first_loopCtrl,
        .second_loopCtrl, .oscEnable, .multi_function_output, .multiFunctionOe);

    function automatic dssc_ref_s exp_ref(input logic [21:0] w);
        dssc_ref_s e;
        e.ratio        = w[16:2];
        e.polarity     = w[17];
        e.currentLevel = w[18];
        e.pumpHighz    = w[19];
        e.lockSel      = w[20];
        e.outFunc      = w[21];
        return e;
    endfunction : exp_ref

    function automatic dssc_fb_s exp_fb(input logic [21:0] w);
        dssc_fb_s e;
        e.swallowCount = w[8:2];
        e.mainCount    = w[19:9];
        e.modulusSel   = w[20];
        e.powerdown    = w[21];
        return e;
    endfunction : exp_fb

    // Mode bits are outFunc, lockSel, highz, current, polarity
    function automatic logic [21:0] refw(input logic [1:0] sel, input logic [4:0] mode);
        return {mode, 15'h0003, sel};
    endfunction : refw

    function automatic logic [21:0] fbw(input logic [1:0] sel, input logic pd);
        return {pd, 1'b0, 11'h003, 7'h00, sel};
    endfunction : fbw

    task automatic send(input logic [21:0] w);
        dssc_host_model_i.send(w);
    endtask : send

    task automatic rand_words();
        logic [79:0] expV;
        logic [21:0] w;
        logic [10:0] mainC;
        logic [6:0]  sw;
        for (int i = 0; i < 12; i++) begin
            w = 22'($random(seed));
            w[1:0] = i[1:0];
            mainC = 11'(3 + $unsigned($random(seed)) % 2045);
            sw = 7'($unsigned($random(seed)) % 64);
            if (11'(sw) > mainC) sw = mainC[6:0];
            if (i[1]) begin
                w[21] = 1'b0;
                w[19:9] = mainC;
                w[8:2] = sw;
            end else begin
                w[16:2] = 15'(3 + $unsigned($random(seed)) % 32765);
            end
            expV = {first_loopRef, second_loopRef, first_loopFb, second_loopFb};
            expV[(w[1] ? (w[0] ? 20 : 0) : (w[0] ? 60 : 40)) +: 20] =
                w[1] ? 20'(exp_fb(w)) : 20'(exp_ref(w));
            send(w);
            `CHK("latches", expV, {first_loopRef, second_loopRef, first_loopFb, second_loopFb})
            if (i[1]) `CHK("fb ratio", (w[20] ? 19'h80 : 19'h40) * 19'(w[19:9]) + 19'(w[8:2]), i[0] ? first_loopCtrl.fbRatio : second_loopCtrl.fbRatio)
            else `CHK("polarity", w[17], i[0] ? first_loopCtrl.polarity : second_loopCtrl.polarity)
        end
    endtask : rand_words

    task automatic mux_modes();
        logic [3:0] want = 4'b0100;
        @(posedge clock);
        loop1Locked <= 1'b1;
        loop1RefOut <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            send(refw(2'h1, {1'b0, c[1], 3'h0}));
            send(refw(2'h0, {1'b0, c[0], 3'h0}));
            `CHK("lock out", want[c], multi_function_output)
        end
        send(refw(2'h1, 5'h10));
        `CHK("fb divider out", 1'b0, multi_function_output)
        send(refw(2'h0, 5'h00));
        `CHK("ref divider out", 1'b1, multi_function_output)
        send(refw(2'h0, 5'h10));
        `CHK("switch open", 1'b0, multiFunctionOe)
        send(refw(2'h1, 5'h12));
        `CHK("switch closed", 2'b10, {multiFunctionOe, multi_function_output})
        `CHK("full current", 1'b1, first_loopCtrl.fullCurrent)
        send(refw(2'h1, 5'h18));
        `CHK("counter reset", 3'b101, {first_loopCtrl.counterReset,
            second_loopCtrl.counterReset, first_loopCtrl.pumpHighz})
    endtask : mux_modes

    task automatic power_modes();
        int n;
        send(refw(2'h1, 5'h04));
        send(fbw(2'h3, 1'b1));
        `CHK("async down", 2'b11, {first_loopCtrl.poweredDown, oscEnable})
        send(refw(2'h0, 5'h04));
        send(fbw(2'h2, 1'b1));
        `CHK("both down", 1'b0, oscEnable)
        send(refw(2'h0, 5'h0d));
        `CHK("latch in powerdown", exp_ref(refw(2'h0, 5'h0d)), second_loopRef)
        send(fbw(2'h3, 1'b0));
        `CHK("power up", 2'b01, {first_loopCtrl.poweredDown, oscEnable})
        send(refw(2'h1, 5'h00));
        send(fbw(2'h3, 1'b1));
        `CHK("sync wait", 1'b0, first_loopCtrl.poweredDown)
        @(posedge clock);
        loop1PumpIdle <= 1'b1;
        n = 0;
        while (first_loopCtrl.poweredDown !== 1'b1 && n < 10) begin
            @(posedge clock);
            n++;
        end
        `CHK("sync down", 1'b1, first_loopCtrl.poweredDown)
        if (n == 10) close_out();
    endtask : power_modes

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    initial begin
        {rst_b, loop1Locked, loop2Locked, loop1PumpIdle, loop2PumpIdle} = 5'h00;
        {loop1RefOut, loop2RefOut, loop1FbOut, loop2FbOut} = 4'h0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        rand_words();
        $display("test random words done");
        mux_modes();
        $display("test output modes done");
        power_modes();
        $display("test powerdown done");
        close_out();
    end
endmodule : dssc_serial_config_test
